// >>> common/fcc_defs.svh
// register map, field positions, reset values and timing figures of the flash command controller
`ifndef FCC_DEFS_SVH
`define FCC_DEFS_SVH
`define FCC_ADR_STATUS  32'hFFFFF800
`define FCC_ADR_MODE    32'hFFFFF804
`define FCC_ADR_CMD     32'hFFFFF808
`define FCC_ADR_DATA    32'hFFFFF80C
`define FCC_ADR_ADDR    32'hFFFFF810
`define FCC_ADR_SIGN    32'hFFFFF818
`define FCC_ST_IRQ      3
`define FCC_ST_BUSY     2
`define FCC_ST_FAIL     1
`define FCC_ST_PASS     0
`define FCC_STATUS_RST  8'h20
`define FCC_MD_KEYEN    6
`define FCC_MD_KEYB5    5
`define FCC_MD_IRQEN    4
`define FCC_MD_WREN     3
`define FCC_MODE_RST    16'h0000
`define FCC_CMD_RST     8'h07
`define FCC_ADDR_RST    16'h0000
`define FCC_DATA_RST    16'h0000
`define FCC_SIGN_RST    24'hFFFFFF
`define FCC_MASS_DAT    16'h3CFF
`define FCC_MASS_ADR    16'hFFC3
`define FCC_PERM_KEY    32'hDEADDEAD
`define FCC_CLK_MHZ     20
`define FCC_WRITE_US    50
`define FCC_ERWR_US     24000
`define FCC_MASS_US     2480000
`define FCC_SIGN_CYC    32778
`define FCC_RESP_OKAY   2'b00
`define FCC_RESP_SLVERR 2'b10
`endif

// >>> common/fcc_pkg.sv
// types of the flash command controller
package fcc_pkg;
    typedef enum logic [7:0] {
        FCC_NULL  = 8'h00,
        FCC_READ  = 8'h01,
        FCC_WRITE = 8'h02,
        FCC_ERWR  = 8'h03,
        FCC_VERIF = 8'h04,
        FCC_ERASE = 8'h05,
        FCC_MASS  = 8'h06,
        FCC_SIGN  = 8'h0B,
        FCC_PROT  = 8'h0C,
        FCC_PING  = 8'h0F
    } fcc_cmd_t;

    typedef enum logic [1:0] {
        FCC_IDLE = 2'b00,
        FCC_RUN  = 2'b01,
        FCC_SIGW = 2'b10
    } fcc_fsm_t;

    // bus slave part of the state
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        aw_hold;
        logic        w_hold;
        logic [31:0] awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
    } fcc_bus_t;

    // array port towards the flash cells
    typedef struct packed {
        logic        req;
        logic [7:0]  op;
        logic [15:0] addr;
        logic [15:0] wdata;
    } fcc_arr_t;

    typedef struct packed {
        fcc_bus_t    bus;
        fcc_arr_t    arr;
        logic [3:0]  status;
        logic [15:0] mode;
        logic [7:0]  cmd;
        logic [15:0] data;
        logic [15:0] addr;
        logic [23:0] sign;
        logic [31:0] key;
        logic        key_set;
        logic        key_perm;
        fcc_fsm_t    fsm;
        logic [7:0]  op;
        logic [31:0] cnt;
    } fcc_state_t;
endpackage

// >>> hdl/fcc_ctrl.sv
// flash command controller: axi4-lite registers, command sequencer and array port
`include "fcc_defs.svh"

module fcc_ctrl #(
    parameter int unsigned ERWR_CYC  = `FCC_ERWR_US * `FCC_CLK_MHZ,
    parameter int unsigned ERASE_CYC = `FCC_ERWR_US * `FCC_CLK_MHZ,
    parameter int unsigned MASS_CYC  = `FCC_MASS_US * `FCC_CLK_MHZ,
    parameter int unsigned SIGN_CYC  = `FCC_SIGN_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [31:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [31:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    output logic             arr_req,
    output logic [7:0]       arr_op,
    output logic [15:0]      arr_addr,
    output logic [15:0]      arr_wdata,
    input  wire logic [15:0] arr_rdata
);
    localparam int unsigned WRITE_CYC = `FCC_WRITE_US * `FCC_CLK_MHZ;

    if (ERWR_CYC < 2 || ERASE_CYC < 2 || MASS_CYC < 2 || SIGN_CYC < 2)
    begin : g_chk
        $error("fcc_ctrl: operation lengths must be at least 2 cycles");
    end

    fcc_pkg::fcc_state_t r;
    fcc_pkg::fcc_state_t s;
    logic                fin_pass;
    logic                fin_fail;
    logic                go;
    logic [7:0]          go_code;

    // =========================================================
    // helpers
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
                res[i*8 +: 8] = nw[i*8 +: 8];
        end
        return res;
    endfunction

    function automatic logic mapped(input logic [31:0] a);
        return a == `FCC_ADR_STATUS || a == `FCC_ADR_MODE || a == `FCC_ADR_CMD ||
               a == `FCC_ADR_DATA || a == `FCC_ADR_ADDR || a == `FCC_ADR_SIGN;
    endfunction

    // =========================================================
    // next state
    always_comb
    begin
        logic [31:0] m;
        logic        ok;
        m        = 32'h0000_0000;
        ok       = 1'b0;
        s        = r;
        fin_pass = 1'b0;
        fin_fail = 1'b0;
        go       = 1'b0;
        go_code  = 8'h00;
        s.arr.req = 1'b0;

        // write channel: address and data taken in either order
        if (awvalid && r.bus.awready)
        begin
            s.bus.aw_hold = 1'b1;
            s.bus.awaddr  = awaddr;
        end
        if (wvalid && r.bus.wready)
        begin
            s.bus.w_hold = 1'b1;
            s.bus.wdata  = wdata;
            s.bus.wstrb  = wstrb;
        end
        if (r.bus.bvalid && bready)
            s.bus.bvalid = 1'b0;
        if (r.bus.aw_hold && r.bus.w_hold && !r.bus.bvalid)
        begin
            s.bus.aw_hold = 1'b0;
            s.bus.w_hold  = 1'b0;
            s.bus.bvalid  = 1'b1;
            ok = mapped(r.bus.awaddr) && r.bus.awaddr != `FCC_ADR_STATUS && r.bus.awaddr != `FCC_ADR_SIGN;
            s.bus.bresp = ok ? `FCC_RESP_OKAY : `FCC_RESP_SLVERR;
            m = merge({16'h0000, r.mode}, r.bus.wdata, r.bus.wstrb);
            case (r.bus.awaddr)
                `FCC_ADR_MODE:
                    s.mode = m[15:0];
                `FCC_ADR_DATA:
                    s.data = 16'(merge({16'h0000, r.data}, r.bus.wdata, r.bus.wstrb));
                `FCC_ADR_ADDR:
                    s.addr = 16'(merge({16'h0000, r.addr}, r.bus.wdata, r.bus.wstrb));
                `FCC_ADR_CMD:
                begin
                    // a command written while busy is dropped; the sequencer owns the register then
                    if (r.bus.wstrb[0] && r.fsm == fcc_pkg::FCC_IDLE)
                    begin
                        go      = 1'b1;
                        go_code = r.bus.wdata[7:0];
                        s.cmd   = go_code;
                    end
                end
                default:
                    s.mode = r.mode;
            endcase
        end

        // read channel; a status read clears the sticky flags
        if (r.bus.rvalid && rready)
            s.bus.rvalid = 1'b0;
        if (arvalid && r.bus.arready)
        begin
            s.bus.rvalid = 1'b1;
            s.bus.rresp  = mapped(araddr) ? `FCC_RESP_OKAY : `FCC_RESP_SLVERR;
            case (araddr)
                `FCC_ADR_STATUS:
                begin
                    s.bus.rdata = {24'h000000, `FCC_STATUS_RST | {4'h0, r.status}};
                    s.status[`FCC_ST_IRQ]  = 1'b0;
                    s.status[`FCC_ST_FAIL] = 1'b0;
                    s.status[`FCC_ST_PASS] = 1'b0;
                end
                `FCC_ADR_MODE:
                    s.bus.rdata = {16'h0000, r.mode};
                `FCC_ADR_CMD:
                    s.bus.rdata = {24'h000000, r.cmd};
                `FCC_ADR_DATA:
                    s.bus.rdata = {16'h0000, r.data};
                `FCC_ADR_ADDR:
                    s.bus.rdata = {16'h0000, r.addr};
                `FCC_ADR_SIGN:
                    s.bus.rdata = {8'h00, r.sign};
                default:
                    s.bus.rdata = 32'h0000_0000;
            endcase
        end

        // command start
        if (go)
        begin
            s.op      = go_code;
            s.arr.op  = go_code;
            s.arr.addr  = r.addr;
            s.arr.wdata = r.data;
            case (go_code)
                fcc_pkg::FCC_NULL:
                    s.cmd = `FCC_CMD_RST;
                fcc_pkg::FCC_READ, fcc_pkg::FCC_VERIF:
                begin
                    s.arr.req = 1'b1;
                    s.fsm     = fcc_pkg::FCC_RUN;
                    s.cnt     = 32'h0000_0000;
                end
                fcc_pkg::FCC_WRITE, fcc_pkg::FCC_ERWR, fcc_pkg::FCC_ERASE, fcc_pkg::FCC_MASS:
                begin
                    if (!r.mode[`FCC_MD_WREN] || (go_code == fcc_pkg::FCC_MASS &&
                        (r.data != `FCC_MASS_DAT || r.addr != `FCC_MASS_ADR)))
                        fin_fail = 1'b1;
                    else
                    begin
                        s.arr.req = 1'b1;
                        s.fsm     = fcc_pkg::FCC_RUN;
                        case (go_code)
                            fcc_pkg::FCC_WRITE:
                                s.cnt = WRITE_CYC - 1;
                            fcc_pkg::FCC_ERWR:
                                s.cnt = ERWR_CYC - 1;
                            fcc_pkg::FCC_ERASE:
                                s.cnt = ERASE_CYC - 1;
                            default:
                            begin
                                s.cnt      = MASS_CYC - 1;
                                s.key_set  = 1'b0;
                                s.key_perm = 1'b0;
                            end
                        endcase
                    end
                end
                fcc_pkg::FCC_SIGN:
                begin
                    s.fsm      = fcc_pkg::FCC_SIGW;
                    s.cnt      = SIGN_CYC - 1;
                    s.sign     = 24'h000000;
                    s.arr.req  = 1'b1;
                    s.arr.addr = 16'h0000;
                end
                fcc_pkg::FCC_PROT:
                begin
                    // the key is stored once; a permanent key locks it until a mass erase clears it
                    if (r.mode[`FCC_MD_KEYEN] && !r.mode[`FCC_MD_KEYB5] &&
                        (!r.key_set || (!r.key_perm && {r.addr, r.data} == r.key)))
                    begin
                        s.key      = {r.addr, r.data};
                        s.key_set  = 1'b1;
                        s.key_perm = {r.addr, r.data} == `FCC_PERM_KEY;
                        s.arr.req  = 1'b1;
                        s.fsm      = fcc_pkg::FCC_RUN;
                        s.cnt      = WRITE_CYC - 1;
                    end
                    else
                        fin_fail = 1'b1;
                end
                fcc_pkg::FCC_PING:
                    fin_pass = 1'b1;
                default:
                    s.op = r.op;
            endcase
        end

        // running operations
        case (r.fsm)
            fcc_pkg::FCC_RUN:
            begin
                if (r.cnt == 32'h0000_0000)
                begin
                    s.fsm = fcc_pkg::FCC_IDLE;
                    if (r.op == fcc_pkg::FCC_READ)
                        s.data = arr_rdata;
                    if (r.op == fcc_pkg::FCC_VERIF && arr_rdata != r.data)
                        fin_fail = 1'b1;
                    else
                        fin_pass = 1'b1;
                end
                else
                    s.cnt = r.cnt - 32'h0000_0001;
            end
            fcc_pkg::FCC_SIGW:
            begin
                // data of the current address arrives each cycle while the walk runs
                s.sign     = {r.sign[22:0], r.sign[23]} ^ {8'h00, arr_rdata};
                s.arr.req  = r.cnt != 32'h0000_0000;
                s.arr.addr = r.arr.addr + 16'h0001;
                if (r.cnt == 32'h0000_0000)
                begin
                    s.fsm    = fcc_pkg::FCC_IDLE;
                    fin_pass = 1'b1;
                end
                else
                    s.cnt = r.cnt - 32'h0000_0001;
            end
            default:
                s.fsm = s.fsm;
        endcase

        // completion events win over a clearing status read in the same cycle
        if (fin_pass || fin_fail)
        begin
            if (fin_pass)
                s.status[`FCC_ST_PASS] = 1'b1;
            if (fin_fail)
                s.status[`FCC_ST_FAIL] = 1'b1;
            if (r.mode[`FCC_MD_IRQEN])
                s.status[`FCC_ST_IRQ] = 1'b1;
            if ((go ? go_code : r.op) <= fcc_pkg::FCC_MASS)
                s.cmd = `FCC_CMD_RST;
        end
        s.status[`FCC_ST_BUSY] = s.fsm != fcc_pkg::FCC_IDLE;

        s.bus.awready = !s.bus.aw_hold && !s.bus.bvalid;
        s.bus.wready  = !s.bus.w_hold && !s.bus.bvalid;
        s.bus.arready = !s.bus.rvalid;
    end

    // =========================================================
    // state register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            r        <= '0;
            r.mode   <= `FCC_MODE_RST;
            r.cmd    <= `FCC_CMD_RST;
            r.addr   <= `FCC_ADDR_RST;
            r.data   <= `FCC_DATA_RST;
            r.sign   <= `FCC_SIGN_RST;
            r.fsm    <= fcc_pkg::FCC_IDLE;
        end
        else
            r <= s;
    end

    assign awready   = r.bus.awready;
    assign wready    = r.bus.wready;
    assign bvalid    = r.bus.bvalid;
    assign bresp     = r.bus.bresp;
    assign arready   = r.bus.arready;
    assign rvalid    = r.bus.rvalid;
    assign rresp     = r.bus.rresp;
    assign rdata     = r.bus.rdata;
    assign arr_req   = r.arr.req;
    assign arr_op    = r.arr.op;
    assign arr_addr  = r.arr.addr;
    assign arr_wdata = r.arr.wdata;

    // =========================================================
    // assertions
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic st_rd;
    assign st_rd = arvalid && arready && araddr == `FCC_ADR_STATUS;

    busy_tracks_a: assert property (r.status[`FCC_ST_BUSY] == (r.fsm != fcc_pkg::FCC_IDLE))
        else $error("busy flag differs from sequencer state");
    irq_set_a: assert property ((fin_pass || fin_fail) && r.mode[`FCC_MD_IRQEN] |=> r.status[`FCC_ST_IRQ])
        else $error("interrupt flag not set on completion");
    irq_off_a: assert property ((fin_pass || fin_fail) && !r.mode[`FCC_MD_IRQEN] && !r.status[`FCC_ST_IRQ]
        |=> !r.status[`FCC_ST_IRQ])
        else $error("interrupt flag set while disabled");
    irq_clear_a: assert property (st_rd && !fin_pass && !fin_fail |=> !r.status[`FCC_ST_IRQ])
        else $error("status read left interrupt flag");
    fail_clear_a: assert property (st_rd && !fin_fail |=> !r.status[`FCC_ST_FAIL])
        else $error("status read left fail flag");
    pass_clear_a: assert property (st_rd && !fin_pass |=> !r.status[`FCC_ST_PASS])
        else $error("status read left pass flag");
    locked_wr_a: assert property (go && go_code == fcc_pkg::FCC_WRITE && !r.mode[`FCC_MD_WREN]
        |=> r.status[`FCC_ST_FAIL] && r.fsm == fcc_pkg::FCC_IDLE && !r.arr.req)
        else $error("protected write reached the array");
    write_busy_a: assert property (go && go_code == fcc_pkg::FCC_WRITE && r.mode[`FCC_MD_WREN]
        |=> r.status[`FCC_ST_BUSY] [*8])
        else $error("write dropped busy too early");
    null_idle_a: assert property (go && go_code == fcc_pkg::FCC_NULL
        |=> r.fsm == fcc_pkg::FCC_IDLE && r.cmd == `FCC_CMD_RST)
        else $error("null command started something");
    cmd_back_a: assert property ((fin_pass || fin_fail) && !go && r.op <= fcc_pkg::FCC_MASS
        |=> r.cmd == `FCC_CMD_RST)
        else $error("command register not back to idle code");

    read_c: cover property (go && go_code == fcc_pkg::FCC_READ ##2 r.status[`FCC_ST_PASS]);
    write_c: cover property (r.op == fcc_pkg::FCC_WRITE && fin_pass);
    sign_c: cover property (r.fsm == fcc_pkg::FCC_SIGW ##1 r.fsm == fcc_pkg::FCC_IDLE);
    ping_c: cover property (go && go_code == fcc_pkg::FCC_PING && r.mode[`FCC_MD_IRQEN]);
endmodule

// >>> verif/flash_command_controller_tb.sv
// self-checking testbench of the flash command controller
`include "fcc_defs.svh"

module flash_command_controller_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic        aclk;
    logic        aresetn;
    logic [31:0] awaddr;
    logic        awvalid;
    logic        awready;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready;
    logic [31:0] araddr;
    logic        arvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready;
    logic        arr_req;
    logic [7:0]  arr_op;
    logic [15:0] arr_addr;
    logic [15:0] arr_wdata;
    logic [15:0] arr_rdata;
    int          fails;
    int          checks_done;
    int          seed;
    logic [31:0] v;
    logic [1:0]  r;
    logic [15:0] a;
    logic [15:0] d;
    int          req_seen;
    int          req_base;
    logic [7:0]  locked_cmds [4] = '{8'h02, 8'h03, 8'h05, 8'h06};

    localparam int SIGN_N = 28;

    // small counts keep the long erase runs short
    fcc_ctrl #(.ERWR_CYC(20), .ERASE_CYC(24), .MASS_CYC(30), .SIGN_CYC(SIGN_N)) fcc_ctrl_inst (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .arr_req(arr_req), .arr_op(arr_op),
        .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_rdata(arr_rdata));

    // ==========================================
    // array stand-in: contents derived from the address
    function automatic logic [15:0] word_at(input logic [15:0] x);
        return x ^ 16'hA5C3;
    endfunction

    assign arr_rdata = word_at(arr_addr);

    // rotate-left-and-xor fold over the first words of the stand-in array
    function automatic logic [23:0] sign_exp(input int words);
        logic [23:0] x;
        x = 24'h000000;
        for (int i = 0; i < words; i++)
            x = {x[22:0], x[23]} ^ {8'h00, word_at(16'(i))};
        return x;
    endfunction

    // cycles with an array request, to tell which commands reach the array
    always @(posedge aclk)
    begin
        if (arr_req)
            req_seen <= req_seen + 1;
    end

    initial
    begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // ==========================================
    // bus tasks and checks
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [31:0] ad, input logic [31:0] dt, output logic [1:0] rs);
        int n;
        @(posedge aclk);
        awaddr  <= ad;
        awvalid <= 1'b1;
        wdata   <= dt;
        wstrb   <= 4'hF;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end
        while (!bvalid && n < 100);
        if (n >= 100)
        begin
            fails++;
            end_of_test();
        end
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] ad, output logic [31:0] dt, output logic [1:0] rs);
        int n;
        @(posedge aclk);
        araddr  <= ad;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end
        while (!rvalid && n < 100);
        if (n >= 100)
        begin
            fails++;
            end_of_test();
        end
        dt = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    // issue a command, poll until idle, compare busy history and final status
    task automatic run_cmd(input logic [7:0] c, input logic busy_exp, input logic [7:0] st_exp);
        logic [31:0] s;
        logic [1:0]  q;
        logic        saw;
        int          n;
        wr(`FCC_ADR_CMD, {24'h0, c}, q);
        chk("cmd_bresp", `FCC_RESP_OKAY, q);
        saw = 1'b0;
        n = 0;
        do
        begin
            rd(`FCC_ADR_STATUS, s, q);
            saw = saw | s[2];
            n++;
        end
        while (s[2] && n < 2000);
        if (n >= 2000)
        begin
            fails++;
            end_of_test();
        end
        chk("busy_seen", busy_exp, saw);
        chk("status", st_exp, s);
        if (c <= 8'h06)
        begin
            rd(`FCC_ADR_CMD, s, q);
            chk("cmd_after", 32'h07, s);
        end
    endtask

    // ==========================================
    // main sequence
    initial
    begin
        fails = 0;
        checks_done = 0;
        seed = 32'hBF51;
        aresetn = 1'b0;
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`FCC_ADR_STATUS, v, r);
        chk("status_rst", 32'h20, v);
        rd(`FCC_ADR_MODE, v, r);
        chk("mode_rst", 32'h0, v);
        rd(`FCC_ADR_CMD, v, r);
        chk("cmd_rst", 32'h07, v);
        rd(`FCC_ADR_ADDR, v, r);
        chk("addr_rst", 32'h0, v);
        rd(`FCC_ADR_SIGN, v, r);
        chk("sign_rst", 32'h00FF_FFFF, v);
        rd(32'hFFFFF830, v, r);
        chk("unmapped_resp", `FCC_RESP_SLVERR, r);
        wr(`FCC_ADR_STATUS, 32'hFF, r);
        chk("status_ro", `FCC_RESP_SLVERR, r);
        for (int i = 0; i < 4; i++)
        begin
            a = 16'($random(seed));
            d = 16'($random(seed));
            wr(`FCC_ADR_ADDR, {16'hFFFF, a}, r);
            wr(`FCC_ADR_DATA, {16'hFFFF, d}, r);
            rd(`FCC_ADR_ADDR, v, r);
            chk("addr_rb", {16'h0, a}, v);
            rd(`FCC_ADR_DATA, v, r);
            chk("data_rb", {16'h0, d}, v);
        end
        // erase and write refused while write enable bit is clear
        wr(`FCC_ADR_MODE, 32'h0, r);
        foreach (locked_cmds[k])
            run_cmd(locked_cmds[k], 1'b0, 8'h22);
        chk("locked_reqs", 32'h0, req_seen);
        rd(`FCC_ADR_STATUS, v, r);
        chk("fail_clr", 32'h20, v);
        wr(`FCC_ADR_MODE, 32'h18, r);
        run_cmd(8'h0F, 1'b0, 8'h29);
        rd(`FCC_ADR_STATUS, v, r);
        chk("irq_clr", 32'h20, v);
        wr(`FCC_ADR_MODE, 32'h08, r);
        run_cmd(8'h0F, 1'b0, 8'h21);
        run_cmd(8'h00, 1'b0, 8'h20);
        for (int i = 0; i < 3; i++)
        begin
            a = 16'($random(seed));
            wr(`FCC_ADR_ADDR, {16'h0, a}, r);
            run_cmd(8'h01, 1'b0, 8'h21);
            rd(`FCC_ADR_DATA, v, r);
            chk("read_word", {16'h0, word_at(a)}, v);
            run_cmd(8'h04, 1'b0, 8'h21);
            wr(`FCC_ADR_DATA, {16'h0, ~word_at(a)}, r);
            run_cmd(8'h04, 1'b0, 8'h22);
        end
        req_base = req_seen;
        run_cmd(8'h02, 1'b1, 8'h21);
        chk("write_reqs", 32'h1, req_seen - req_base);
        chk("arr_op", 32'h02, arr_op);
        chk("arr_addr", {16'h0, a}, arr_addr);
        chk("arr_wdata", {16'h0, ~word_at(a)}, arr_wdata);
        run_cmd(8'h03, 1'b1, 8'h21);
        run_cmd(8'h05, 1'b1, 8'h21);
        req_base = req_seen;
        run_cmd(8'h0B, 1'b1, 8'h21);
        chk("sign_reqs", SIGN_N, req_seen - req_base);
        rd(`FCC_ADR_SIGN, v, r);
        chk("signature", {8'h00, sign_exp(SIGN_N)}, v);
        // the key is stored once; a different key is refused afterwards
        wr(`FCC_ADR_MODE, 32'h48, r);
        wr(`FCC_ADR_ADDR, 32'h1234, r);
        wr(`FCC_ADR_DATA, 32'h5678, r);
        run_cmd(8'h0C, 1'b1, 8'h21);
        wr(`FCC_ADR_DATA, 32'h5679, r);
        run_cmd(8'h0C, 1'b0, 8'h22);
        wr(`FCC_ADR_DATA, 32'h1234, r);
        wr(`FCC_ADR_ADDR, {16'h0, `FCC_MASS_ADR}, r);
        run_cmd(8'h06, 1'b0, 8'h22);
        wr(`FCC_ADR_DATA, {16'h0, `FCC_MASS_DAT}, r);
        run_cmd(8'h06, 1'b1, 8'h21);
        // mass erase forgets the stored key, so a new one is taken
        run_cmd(8'h0C, 1'b1, 8'h21);
        end_of_test();
    end
endmodule
